/* core/fifo_chain_ctrl.sv */
// apb controlled host that drives a chain of strobe-timed fifo devices
//
// Contract
// - composite flags asserted only when all assert in depth mode; single mode follows device 0
// - first device first-load low during reset in depth mode
// - other devices first-load high during reset
// - never retransmit in depth-expansion mode
// - chain-out wired to next chain-in
// - chain-in leads enabled strobe by setup
// - writer watches full, reader watches empty
// - expansions combine with bidirectional pairing
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
module fifo_chain_ctrl
  import chain_ctrl_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic      [DW-1:0]   data_out,
  input  wire logic [DW-1:0]   data_in,
  output logic                 write_strobe_n,
  output logic                 read_strobe_n,
  output logic                 clear_in_n,
  output logic      [NDEV-1:0] first_load_select_n,
  output logic                 chain_in_pulse_n,
  input  wire logic            chain_out_pulse_n,
  input  wire logic [NDEV-1:0] empty_flag_n,
  input  wire logic [NDEV-1:0] full_flag_n,
  input  wire logic            half_full_flag_n
);

  // ==========================================================================
  // pin synchronisers
  localparam int SYNC_W = 2 * NDEV + 2 + DW;

  logic [SYNC_W-1:0] pins_sync;
  logic [NDEV-1:0]   empty_s;
  logic [NDEV-1:0]   full_s;
  logic              half_s;
  logic              chain_ret_s;
  logic [DW-1:0]     data_s;

  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_in       ({empty_flag_n, full_flag_n, half_full_flag_n, chain_out_pulse_n, data_in}),
    .pin_sync_out (pins_sync)
  );

  assign {empty_s, full_s, half_s, chain_ret_s, data_s} = pins_sync;

  // ==========================================================================
  // state
  state_t          state_r;
  state_t          state_nxt;
  op_t             op_r;
  op_t             op_nxt;
  logic            depth_cfg_r;
  logic            depth_r;
  logic            depth_nxt;
  logic            init_r;
  logic [DW-1:0]   wdata_r;
  logic [DW-1:0]   rdata_r;
  logic            rvalid_r;
  logic            refused_r;
  logic            wr_n_r;
  logic            rd_n_r;
  logic            clr_n_r;
  logic            fl0_n_r;
  logic            chain_in_r;

  // ==========================================================================
  // composite flags
  // single mode watches device 0 only; depth mode needs every device to agree
  wire comp_empty = depth_r ? (&(~empty_s)) : ~empty_s[0];
  wire comp_full  = depth_r ? (&(~full_s))  : ~full_s[0];
  // the half-full pin carries nothing in depth mode
  wire half_full  = ~depth_r & ~half_s;

  // ==========================================================================
  // apb decode
  wire acc       = psel & penable;
  wire setup     = psel & ~penable;
  wire wr_acc    = acc & pwrite;
  wire rd_acc    = acc & ~pwrite;
  wire hit_ctrl  = (paddr == ADDR_CTRL);
  wire hit_cmd   = (paddr == ADDR_CMD);
  wire hit_wdata = (paddr == ADDR_WDATA);
  wire hit_rdata = (paddr == ADDR_RDATA);
  wire hit_stat  = (paddr == ADDR_STATUS);
  wire mapped    = hit_ctrl | hit_cmd | hit_wdata | hit_rdata | hit_stat;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ==========================================================================
  // command acceptance
  wire idle      = (state_r == ST_IDLE);
  wire req_rst   = wr_acc & hit_cmd & pwdata[CMD_RST_BIT];
  wire req_rd    = wr_acc & hit_cmd & pwdata[CMD_RD_BIT] & ~pwdata[CMD_RST_BIT];
  wire req_rt    = wr_acc & hit_cmd & pwdata[CMD_RT_BIT] & ~pwdata[CMD_RST_BIT] & ~pwdata[CMD_RD_BIT];
  wire req_wr    = wr_acc & hit_wdata;
  wire go_rst    = req_rst & idle;
  // the writer is held off by full, the reader by empty
  wire go_wr     = req_wr & idle & init_r & ~comp_full;
  wire go_rd     = req_rd & idle & init_r & ~comp_empty;
  // retransmit would corrupt a daisy chain, so it is refused there
  wire go_rt     = req_rt & idle & init_r & ~depth_r;
  wire go_any    = go_rst | go_wr | go_rd | go_rt;
  wire refuse    = (req_rst | req_wr | req_rd | req_rt) & ~go_any;
  wire clr_ref   = wr_acc & hit_stat & pwdata[ST_REFUSED_BIT];
  wire clr_rv    = rd_acc & hit_rdata;

  // ==========================================================================
  // sequencer timer
  timer_if tif ();

  pulse_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tmr     (tif.timer)
  );

  wire pulse_end = (state_r == ST_PULSE) & tif.done;
  wire gap_end   = (state_r == ST_GAP) & tif.done;

  assign tif.load  = go_any | pulse_end;
  assign tif.count = pulse_end ? GAP_CNT :
                     go_rst    ? RST_CNT :
                     go_rd     ? RD_CNT  :
                     go_rt     ? RT_CNT  : WR_CNT;

  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    depth_nxt = depth_r;
    unique case (state_r)
      ST_IDLE: begin
        if (go_any) begin
          state_nxt = ST_PULSE;
        end
        if (go_rst) begin
          op_nxt    = OP_RST;
          depth_nxt = depth_cfg_r;
        end else if (go_rd) begin
          op_nxt = OP_RD;
        end else if (go_rt) begin
          op_nxt = OP_RT;
        end else if (go_wr) begin
          op_nxt = OP_WR;
        end
      end
      ST_PULSE: begin
        if (tif.done) begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        // gap covers flag settling, recovery and chain-in setup
        if (tif.done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  wire pulsing_nxt = (state_nxt == ST_PULSE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      op_r    <= OP_WR;
      depth_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      depth_r <= depth_nxt;
    end
  end

  // ==========================================================================
  // pin drivers, all from flip-flops or constants so the async device sees no glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_n_r     <= 1'b1;
      rd_n_r     <= 1'b1;
      clr_n_r    <= 1'b1;
      fl0_n_r    <= 1'b1;
      chain_in_r <= 1'b0;
    end else begin
      wr_n_r  <= ~(pulsing_nxt & (op_nxt == OP_WR));
      rd_n_r  <= ~(pulsing_nxt & (op_nxt == OP_RD));
      clr_n_r <= ~(pulsing_nxt & (op_nxt == OP_RST));
      // depth mode grounds first-load of the head device
      fl0_n_r <= depth_nxt ? 1'b0 : ~(pulsing_nxt & (op_nxt == OP_RT));
      // single mode keeps chain-in low; depth closes the ring from the tail
      chain_in_r <= depth_nxt ? chain_ret_s : 1'b0;
    end
  end

  assign write_strobe_n   = wr_n_r;
  assign read_strobe_n    = rd_n_r;
  assign clear_in_n       = clr_n_r;
  assign chain_in_pulse_n = chain_in_r;

  for (genvar d = 0; d < NDEV; d++) begin : g_fl
    if (d == 0) begin : g_head
      assign first_load_select_n[d] = fl0_n_r;
    end else begin : g_tail
      assign first_load_select_n[d] = 1'b1;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_cfg_r <= 1'b0;
      wdata_r     <= '0;
      rdata_r     <= '0;
      rvalid_r    <= 1'b0;
      refused_r   <= 1'b0;
      init_r      <= 1'b0;
    end else begin
      if (wr_acc & hit_ctrl) begin
        depth_cfg_r <= pwdata[CTRL_DEPTH_BIT];
      end
      if (go_wr) begin
        wdata_r <= pwdata[DW-1:0];
      end
      // data is sampled while the read strobe is still low
      if (pulse_end & (op_r == OP_RD)) begin
        rdata_r <= data_s;
      end
      // set wins over clear on both sticky bits
      rvalid_r  <= (pulse_end & (op_r == OP_RD)) | (rvalid_r & ~clr_rv);
      refused_r <= refuse | (refused_r & ~clr_ref);
      if (go_rst) begin
        init_r <= 1'b0;
      end else if (gap_end & (op_r == OP_RST)) begin
        init_r <= 1'b1;
      end
    end
  end

  assign data_out = wdata_r;

  // ==========================================================================
  // read data, latched in the setup phase
  logic [31:0] status_w;
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;

  always_comb begin
    status_w                 = ZERO32;
    status_w[ST_BUSY_BIT]    = ~idle;
    status_w[ST_EMPTY_BIT]   = comp_empty;
    status_w[ST_FULL_BIT]    = comp_full;
    status_w[ST_HALF_BIT]    = half_full;
    status_w[ST_REFUSED_BIT] = refused_r;
    status_w[ST_RVALID_BIT]  = rvalid_r;
    status_w[ST_DEPTH_BIT]   = depth_r;
    status_w[ST_INIT_BIT]    = init_r;
  end

  assign rd_mux = hit_ctrl  ? {31'h0000_0000, depth_cfg_r} :
                  hit_wdata ? {23'h00_0000, wdata_r}       :
                  hit_rdata ? {23'h00_0000, rdata_r}       :
                  hit_stat  ? status_w                     : ZERO32;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= ZERO32;
    end else if (setup & ~pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;

endmodule

/* core/chain_ctrl_pkg.sv */
// constants, register map and types for the fifo chain controller
package chain_ctrl_pkg;

  // ==========================================================================
  // structure
  localparam int NDEV        = 2;
  localparam int DW          = 9;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W       = 4;

  // ==========================================================================
  // timing, slowest speed grade
  localparam int CLK_NS         = 20;
  localparam int T_WR_PULSE_NS  = 120;
  localparam int T_ACCESS_NS    = 120;
  localparam int T_RD_PULSE_NS  = 120;
  localparam int T_RECOV_NS     = 20;
  localparam int T_RST_PULSE_NS = 120;
  localparam int T_RST_SETUP_NS = 100;
  localparam int T_RT_PULSE_NS  = 120;
  localparam int T_RT_SETUP_NS  = 100;
  localparam int CHAIN_IN_SETUP_TIME_NS       = 15;
  localparam int T_XO_NS        = 90;
  localparam int T_FLAG_NS      = 60;

  localparam int WR_CYC   = (T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACC   = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int RD_PW    = (T_RD_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC   = (RD_ACC > RD_PW) ? RD_ACC : RD_PW;
  localparam int RST_MAX  = (T_RST_PULSE_NS > T_RST_SETUP_NS) ? T_RST_PULSE_NS : T_RST_SETUP_NS;
  localparam int RST_CYC  = (RST_MAX + CLK_NS - 1) / CLK_NS;
  localparam int RT_MAX   = (T_RT_PULSE_NS > T_RT_SETUP_NS) ? T_RT_PULSE_NS : T_RT_SETUP_NS;
  localparam int RT_CYC   = (RT_MAX + CLK_NS - 1) / CLK_NS;
  localparam int GAP_FLAG = (T_FLAG_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int GAP_XI   = (T_XO_NS + CHAIN_IN_SETUP_TIME_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1;
  localparam int GAP_REC  = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_A    = (GAP_FLAG > GAP_XI) ? GAP_FLAG : GAP_XI;
  localparam int GAP_CYC  = (GAP_A > GAP_REC) ? GAP_A : GAP_REC;

  localparam logic [CNT_W-1:0] WR_CNT  = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] RD_CNT  = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] RST_CNT = CNT_W'(RST_CYC);
  localparam logic [CNT_W-1:0] RT_CNT  = CNT_W'(RT_CYC);
  localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_CYC);

  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_WDATA  = 8'h08;
  localparam logic [7:0] ADDR_RDATA  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_DEPTH_BIT = 0;
  localparam int CMD_RST_BIT    = 0;
  localparam int CMD_RD_BIT     = 1;
  localparam int CMD_RT_BIT     = 2;

  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_EMPTY_BIT   = 1;
  localparam int ST_FULL_BIT    = 2;
  localparam int ST_HALF_BIT    = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_RVALID_BIT  = 5;
  localparam int ST_DEPTH_BIT   = 6;
  localparam int ST_INIT_BIT    = 7;

  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {OP_WR, OP_RD, OP_RST, OP_RT} op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_GAP} state_t;

endpackage

/* core/timer_if.sv */
// load / done handshake between the sequencer and its cycle timer
`timescale 1ns/1ns
interface timer_if;
  import chain_ctrl_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             done;
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

/* core/pin_sync.sv */
// two-stage synchroniser for asynchronous device pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  // ==========================================================================
  // per bit synchroniser; the first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_r;
    logic stable_r;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_r   <= 1'b1;
        stable_r <= 1'b1;
      end else begin
        meta_r   <= pin_in[i];
        stable_r <= meta_r;
      end
    end
    assign pin_sync_out[i] = stable_r;
  end
endmodule

/* core/pulse_timer.sv */
// down counter that times strobe low phases and recovery gaps
`timescale 1ns/1ns
module pulse_timer
  import chain_ctrl_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  timer_if.timer    tmr
);
  logic [CNT_W-1:0] cnt_r;

  // a load of n gives done on the n-th cycle after it
  assign tmr.done = (cnt_r == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (tmr.load) begin
      cnt_r <= tmr.count - CNT_W'(1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end
endmodule

/* verif/fifo_dev_model.sv */
// behavioural model of the strobe-timed fifo device at the controller's far side
`timescale 1ns/1ns
module fifo_dev_model
  import chain_ctrl_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input  wire logic          write_strobe_n,
  input  wire logic          read_strobe_n,
  input  wire logic          clear_in_n,
  input  wire logic          first_load_select_n,
  input  wire logic          chain_in_pulse_n,
  input  wire logic [DW-1:0] d,
  output logic      [DW-1:0] q,
  output logic      [1:0]    empty_flag_n,
  output logic      [1:0]    full_flag_n,
  output logic               half_full_flag_n,
  output logic               chain_out_pulse_n
);
  logic [DW-1:0] mem [DEPTH];
  int            wptr = 0;
  int            rptr = 0;
  int            cnt = 0;
  logic          depth_mode = 1'b0;
  logic          rd_ok = 1'b0;
  logic          xo_w = 1'b0;
  logic          xo_r = 1'b0;
  logic          fl_hi = 1'b0;
  int            n_xi = 0;
  initial begin
    q = '0;
    half_full_flag_n = 1'b1;
  end
  // ==========================================================================
  // flags; the second device never fills and stays empty, so composite empty hinges on device 0 and composite full never sets in depth mode
  assign empty_flag_n = {1'b0, cnt != 0};
  assign full_flag_n = {1'b1, cnt != DEPTH};
  assign #10 chain_out_pulse_n = !((xo_w && !write_strobe_n) || (xo_r && !read_strobe_n));
  // ==========================================================================
  // pointers
  always @(negedge clear_in_n) begin
    wptr = 0;
    rptr = 0;
    cnt = 0;
    half_full_flag_n = 1'b1;
  end
  always @(posedge clear_in_n) begin
    depth_mode = chain_in_pulse_n;
    fl_hi = first_load_select_n;
    n_xi = 0;
  end
  always @(negedge chain_in_pulse_n) if (clear_in_n) n_xi++;
  // data lands on the same edge as the strobe, so look a moment later
  always @(negedge write_strobe_n) #1 if (clear_in_n && cnt < DEPTH && (!depth_mode || !fl_hi || n_xi >= 1)) begin
    mem[wptr] = d;
    xo_w = depth_mode && wptr == DEPTH - 1;
    wptr = (wptr + 1) % DEPTH;
    cnt++;
    if (!depth_mode && cnt > DEPTH / 2) half_full_flag_n = 1'b0;
  end
  always @(negedge read_strobe_n) begin
    rd_ok = clear_in_n && cnt != 0 && (!depth_mode || !fl_hi || n_xi >= 2);
    xo_r = rd_ok && depth_mode && rptr == DEPTH - 1;
    if (rd_ok) q = mem[rptr];
  end
  always @(posedge read_strobe_n) begin
    // released outputs show the inverse so stale data cannot pass
    q = ~q;
    if (rd_ok) begin
      rptr = (rptr + 1) % DEPTH;
      cnt--;
      if (cnt <= DEPTH / 2) half_full_flag_n = 1'b1;
    end
  end
  always @(negedge first_load_select_n) #1 if (clear_in_n && !depth_mode) begin
    rptr = 0;
    cnt = wptr;
  end
endmodule

/* verif/fifo_chain_ctrl_assertions.sv */
// concurrent checks on the controller's device pins and bus response
`timescale 1ns/1ns
module fifo_chain_ctrl_checker
  import chain_ctrl_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic [7:0]      paddr,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pslverr,
  input wire logic [DW-1:0]   data_out,
  input wire logic            write_strobe_n,
  input wire logic            read_strobe_n,
  input wire logic            clear_in_n,
  input wire logic [NDEV-1:0] first_load_select_n,
  input wire logic            chain_in_pulse_n,
  input wire logic            chain_out_pulse_n
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped;
  assign mapped = paddr inside {ADDR_CTRL, ADDR_CMD, ADDR_WDATA, ADDR_RDATA, ADDR_STATUS};
  // ==========================================================================
  // pulse shapes, pin levels and bus response
  sequence low6(s);
    !s [*6] ##1 s;
  endsequence
  sequence wr_hold;
    (!write_strobe_n && $stable(data_out)) [*5] ##1 write_strobe_n;
  endsequence
  a_clear_width: assert property ($fell(clear_in_n) |-> low6(clear_in_n)) else $error("clear pulse width");
  a_write_width: assert property ($fell(write_strobe_n) |-> ##1 wr_hold) else $error("write pulse");
  a_read_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*8] ##1 read_strobe_n)
    else $error("read pulse width");
  a_rt_width: assert property ($fell(first_load_select_n[0]) && clear_in_n |-> low6(first_load_select_n[0]))
    else $error("retransmit pulse width");
  a_fl_second: assert property (first_load_select_n[1]) else $error("second first-load low");
  a_fl_steady: assert property (!clear_in_n && !$fell(clear_in_n) |-> $stable(first_load_select_n))
    else $error("first-load moved during clear");
  a_clear_quiet: assert property (!clear_in_n |-> write_strobe_n && read_strobe_n) else $error("strobe in clear");
  a_chain_relay: assert property (!first_load_select_n[0] && clear_in_n && $fell(chain_out_pulse_n)
    |-> ##3 $fell(chain_in_pulse_n)) else $error("chain pulse not relayed");
  a_chain_setup: assert property ($fell(write_strobe_n) || $fell(read_strobe_n) |-> $stable(chain_in_pulse_n))
    else $error("chain-in moved at strobe");
  a_single_ground: assert property (first_load_select_n[0] && $past(first_load_select_n[0], 4) |-> !chain_in_pulse_n)
    else $error("chain-in not grounded");
  a_slverr_map: assert property (psel && penable |-> pslverr == !mapped) else $error("pslverr wrong");
endmodule

bind fifo_chain_ctrl fifo_chain_ctrl_checker i_chk (
  .pclk                (pclk),
  .presetn             (presetn),
  .paddr               (paddr),
  .psel                (psel),
  .penable             (penable),
  .pslverr             (pslverr),
  .data_out            (data_out),
  .write_strobe_n      (write_strobe_n),
  .read_strobe_n       (read_strobe_n),
  .clear_in_n          (clear_in_n),
  .first_load_select_n (first_load_select_n),
  .chain_in_pulse_n    (chain_in_pulse_n),
  .chain_out_pulse_n   (chain_out_pulse_n)
);

/* verif/fifo_chain_ctrl_bench.sv */
// self-checking bench: apb host driving the controller against the device model
`timescale 1ns/1ns
module fifo_chain_ctrl_bench;
  import chain_ctrl_pkg::*;
  localparam int DEPTH = 4;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [DW-1:0]   d, q;
  logic            w_n, r_n, clr_n, ci_n, co_n, hf_n;
  logic [NDEV-1:0] fl_n, ef_n, ff_n;
  int              n_fail, comparisons, n_ci;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, a, e); end end
  fifo_chain_ctrl i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_out(d),
    .data_in(q), .write_strobe_n(w_n), .read_strobe_n(r_n), .clear_in_n(clr_n), .first_load_select_n(fl_n),
    .chain_in_pulse_n(ci_n), .chain_out_pulse_n(co_n), .empty_flag_n(ef_n), .full_flag_n(ff_n),
    .half_full_flag_n(hf_n));
  fifo_dev_model #(.DEPTH(DEPTH)) i_dev (.write_strobe_n(w_n), .read_strobe_n(r_n), .clear_in_n(clr_n),
    .first_load_select_n(fl_n[0]), .chain_in_pulse_n(ci_n), .d(d), .q(q), .empty_flag_n(ef_n),
    .full_flag_n(ff_n), .half_full_flag_n(hf_n), .chain_out_pulse_n(co_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(negedge ci_n) n_ci++;
  // ==========================================================================
  // bus tasks
  // waits only for pready; the watchdog ends a hung bus
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic st(input int b, input logic e);
    apb(1'b0, ADDR_STATUS, ZERO32);
    `CHK(rd[b], e)
  endtask
  // a command is finished once busy has dropped
  task automatic cmd(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    do begin
      apb(1'b0, ADDR_STATUS, ZERO32);
    end while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic rd_word(input logic [DW-1:0] e);
    cmd(ADDR_CMD, 32'h0000_0002);
    apb(1'b0, ADDR_RDATA, ZERO32);
    `CHK(rd[DW-1:0], e)
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_idle;
    `CHK({w_n, r_n, clr_n, fl_n, ci_n}, 6'b111110)
    st(ST_INIT_BIT, 1'b0);
    apb(1'b1, ADDR_WDATA, 32'h0000_0055);
    `CHK(w_n, 1'b1)
    st(ST_REFUSED_BIT, 1'b1);
    apb(1'b0, 8'h20, ZERO32);
    `CHK(err, 1'b1)
  endtask
  task automatic t_single;
    int i;
    apb(1'b1, ADDR_CTRL, ZERO32);
    cmd(ADDR_CMD, 32'h0000_0001);
    st(ST_EMPTY_BIT, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h0000_0010);
    for (i = 0; i < 3; i++) begin
      cmd(ADDR_WDATA, 32'h0000_0100 + i);
      st(ST_HALF_BIT, i == 2);
    end
    rd_word(9'h100);
    cmd(ADDR_CMD, 32'h0000_0004);
    rd_word(9'h100);
    st(ST_HALF_BIT, 1'b0);
    cmd(ADDR_WDATA, 32'h0000_0103);
    cmd(ADDR_WDATA, 32'h0000_0104);
    st(ST_FULL_BIT, 1'b1);
    cmd(ADDR_WDATA, 32'h0000_0105);
    st(ST_REFUSED_BIT, 1'b1);
    for (i = 1; i < 5; i++) rd_word(9'h100 + i);
    st(ST_EMPTY_BIT, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h0000_0010);
    cmd(ADDR_CMD, 32'h0000_0002);
    st(ST_REFUSED_BIT, 1'b1);
  endtask
  task automatic t_depth;
    int i;
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    cmd(ADDR_CMD, 32'h0000_0001);
    `CHK(fl_n, 2'b10)
    st(ST_DEPTH_BIT, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h0000_0010);
    cmd(ADDR_CMD, 32'h0000_0004);
    st(ST_REFUSED_BIT, 1'b1);
    n_ci = 0;
    for (i = 0; i < DEPTH; i++) cmd(ADDR_WDATA, 32'h0000_0080 + i);
    `CHK(n_ci, 1)
    st(ST_HALF_BIT, 1'b0);
    st(ST_FULL_BIT, 1'b0);
    for (i = 0; i < DEPTH; i++) rd_word(9'h080 + i);
    `CHK(n_ci, 2)
    st(ST_EMPTY_BIT, 1'b1);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = ZERO32;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_idle;
    t_single;
    t_depth;
    end_of_test;
  end
  // the sequence needs some 630 cycles; allow about sixteen times that
  initial begin
    #200000;
    n_fail++;
    end_of_test;
  end
endmodule
